// [dspd_consts.svh]
`ifndef DSPD_CONSTS_SVH
`define DSPD_CONSTS_SVH

// register byte offsets on the avalon slave
`define DSPD_OFS_CTRL 4'h0
`define DSPD_OFS_MODE 4'h4
`define DSPD_OFS_STAT 4'h8
`define DSPD_OFS_CNT 4'hc

// field positions and reset values
`define DSPD_CTRL_EN_BIT 0
`define DSPD_CTRL_RST 1'h1
`define DSPD_STAT_FLAG_BIT 0
`define DSPD_STAT_BRANCH_TEST_CODE_BIT 1
`define DSPD_MODE_RST 1'h0
`define DSPD_FLAG_RST 1'h0

// arithmetic function field
`define DSPD_ARITH_NOP 5'h00
`define DSPD_ARITH_ALU_BIT 4
`define DSPD_ARITH_RND_MUL 3'h0
`define DSPD_ARITH_MUL 3'h1
`define DSPD_ARITH_ADD 3'h2
`define DSPD_ARITH_SUB 3'h3
`define DSPD_ARITH_RND_ADD 5'h02
`define DSPD_ARITH_RND_SUB 5'h03

// condition codes
`define DSPD_CC_EQ 4'h0
`define DSPD_CC_NE 4'h1
`define DSPD_CC_GT 4'h2
`define DSPD_CC_LE 4'h3
`define DSPD_CC_LT 4'h4
`define DSPD_CC_GE 4'h5
`define DSPD_CC_AV 4'h6
`define DSPD_CC_NAV 4'h7
`define DSPD_CC_AC 4'h8
`define DSPD_CC_NAC 4'h9
`define DSPD_CC_NEG 4'ha
`define DSPD_CC_POS 4'hb
`define DSPD_CC_MV 4'hc
`define DSPD_CC_NMV 4'hd
`define DSPD_CC_NCE 4'he
`define DSPD_CC_ALWAYS 4'hf

// output pin action codes
`define DSPD_PIN_KEEP 2'h0
`define DSPD_PIN_TOGGLE 2'h1
`define DSPD_PIN_CLEAR 2'h2
`define DSPD_PIN_SET 2'h3

// mode pair codes: high bit arms the change, low bit is the new value
`define DSPD_MC_ARM_BIT 1
`define DSPD_MC_VAL_BIT 0
`define DSPD_MC_OFF 2'h2
`define DSPD_MC_ON 2'h3

// mode indices inside the mode field and the mode register
`define DSPD_MODE_BANK 0
`define DSPD_MODE_BITREV 1
`define DSPD_MODE_OVFL 2
`define DSPD_MODE_SAT 3
`define DSPD_MODE_MPLACE 4
`define DSPD_MODE_GO 5
`define DSPD_MODE_TIMER 6

`endif

// [dspd_pkg.sv]
package dspd_pkg;

  localparam int NMODES = 7;

  typedef struct packed {
    logic [4:0] arith_op_select;
    logic [3:0] branch_test_code;
    logic use_pin_test;
    logic input_pin_test;
    logic loop_count_pop;
    logic mem_access;
    logic mem_dir;
    logic dual_fetch;
    logic [1:0] x_side_fetch_target;
    logic [1:0] y_side_fetch_target;
    logic data_reg_used;
    logic [3:0] data_reg_code;
    logic [1:0] out_pin_action;
    logic dag_select;
    logic loop_stack_pop;
    logic pc_stack_pop;
    logic mode_valid;
    logic [2*NMODES-1:0] mode_ctl;
  } dspd_instr_t;

  typedef struct packed {
    logic az;
    logic an;
    logic av;
    logic ac;
    logic ax_neg;
    logic mv;
    logic ce;
    logic flag_in;
  } dspd_flags_t;

  typedef struct packed {
    logic nop;
    logic mac_op;
    logic mac_round;
    logic mac_acc_add;
    logic mac_acc_sub;
    logic x_signed;
    logic y_signed;
    logic alu_op;
    logic [3:0] alu_func;
    logic branch_test_code_true;
    logic loop_count_pop;
    logic loop_stack_pop;
    logic pc_stack_pop;
    logic mem_read;
    logic mem_write;
    logic dag_second;
    logic [3:0] x_target;
    logic [3:0] y_target;
    logic [15:0] data_reg_sel;
  } dspd_dec_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } dspd_bus_t;

endpackage

// [dspd_branch_test_code_eval.sv]
`timescale 1ns/1ps
`include "dspd_consts.svh"

module dspd_branch_test_code_eval (
  input wire logic [3:0] code, // branch test code
  input wire logic use_pin, // test the latched input pin instead
  input wire logic pin_test, // wanted pin level
  input wire dspd_pkg::dspd_flags_t flags, // status flags
  output logic branch_test_code_true // condition result
);
  import dspd_pkg::*;

  logic lt;

  assign lt = flags.an ^ flags.av;

  always_comb begin
    branch_test_code_true = 1'b0;
    if (use_pin) begin
      branch_test_code_true = (flags.flag_in == pin_test);
    end else begin
      unique case (code)
        `DSPD_CC_EQ: branch_test_code_true = flags.az;
        `DSPD_CC_NE: branch_test_code_true = !flags.az;
        `DSPD_CC_GT: branch_test_code_true = !lt && !flags.az;
        `DSPD_CC_LE: branch_test_code_true = lt || flags.az;
        `DSPD_CC_LT: branch_test_code_true = lt;
        `DSPD_CC_GE: branch_test_code_true = !lt;
        `DSPD_CC_AV: branch_test_code_true = flags.av;
        `DSPD_CC_NAV: branch_test_code_true = !flags.av;
        `DSPD_CC_AC: branch_test_code_true = flags.ac;
        `DSPD_CC_NAC: branch_test_code_true = !flags.ac;
        `DSPD_CC_NEG: branch_test_code_true = flags.ax_neg;
        `DSPD_CC_POS: branch_test_code_true = !flags.ax_neg;
        `DSPD_CC_MV: branch_test_code_true = flags.mv;
        `DSPD_CC_NMV: branch_test_code_true = !flags.mv;
        `DSPD_CC_NCE: branch_test_code_true = !flags.ce;
        `DSPD_CC_ALWAYS: branch_test_code_true = 1'b1;
      endcase
    end
  end
endmodule

// [dspd_mode_bit.sv]
`timescale 1ns/1ps
`include "dspd_consts.svh"

module dspd_mode_bit (
  input wire logic mclk, // clock
  input wire logic rst, // async reset
  input wire logic apply, // mode instruction taken
  input wire logic [1:0] code, // pair code for this mode
  input wire logic sw_we, // software write
  input wire logic sw_val, // software value
  output logic mode // current mode level
);
  // an armed instruction pair wins over a software write in the same cycle,
  // since the program flow depends on it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode <= `DSPD_MODE_RST;
    end else if (apply && code[`DSPD_MC_ARM_BIT]) begin
      mode <= code[`DSPD_MC_VAL_BIT];
    end else if (sw_we) begin
      mode <= sw_val;
    end
  end
endmodule

// [dspd_decoder.sv]
// Behaviour
// - a 5-bit arithmetic field is a no-op at all zeros, a multiplier product (rounded or signed/unsigned, alone, added or subtracted) with leading 0, else an arithmetic-unit op.
// - the 4-bit condition gives equal, not equal, greater, less-or-equal, less, greater-or-equal first, then 1110 counter not expired and 1111 always.
// - codes 0110 to 1101 test overflow, carry, X sign and multiplier overflow as true and complement pairs.
// - the counter-pop bit at 1 pops the loop-counter stack, at 0 leaves it.
// - a direction bit of 0 reads memory and 1 writes it.
// - the 2-bit data-memory target picks first/second arithmetic X, then first/second multiplier X.
// - the 2-bit program-memory target picks first/second arithmetic Y, then first/second multiplier Y.
// - the output pin code keeps, toggles, clears or sets the pin for 00, 01, 10, 11.
// - the address-generator bit picks the first generator at 0 and the second at 1.
// - the loop-pop bit at 1 pops the loop stack, at 0 leaves it.
// - the pc-pop bit at 1 pops the program-counter stack, at 0 leaves it.
// - each mode pair leaves the mode with leading 0, clears it with 10 and sets it with 11.
// - seven modes are held: register bank, bit reverse, overflow latch, saturate, multiplier placement, go mode, timer.
`timescale 1ns/1ps
`include "dspd_consts.svh"

module dspd_decoder #(
  parameter int CNT_W = 16 // width of the decoded-instruction counter
) (
  input wire logic mclk, // 20 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic instr_valid, // instruction fields present
  input wire dspd_pkg::dspd_instr_t instr, // instruction fields
  input wire dspd_pkg::dspd_flags_t flags, // datapath status
  output dspd_pkg::dspd_dec_t dec, // decoded controls
  output logic dec_valid, // dec holds a fresh decode
  output logic flag_out, // output flag pin level
  output logic [dspd_pkg::NMODES-1:0] modes, // mode levels
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest // stall
);
  import dspd_pkg::*;

  dspd_bus_t bus_st;
  logic decode_en;
  logic go;
  logic branch_test_code_now;
  logic last_branch_test_code;
  logic [CNT_W-1:0] dec_count;
  logic bus_req;
  logic bus_done;
  logic sw_mode_we;
  dspd_dec_t next_dec;

  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && (bus_st == BUS_IDLE);
  assign bus_done = bus_req && (bus_st == BUS_ACK);
  assign go = instr_valid && decode_en;
  assign sw_mode_we = bus_done && avs_write && (avs_address == `DSPD_OFS_MODE);

  dspd_branch_test_code_eval u_branch_test_code (
    .code(instr.branch_test_code),
    .use_pin(instr.use_pin_test),
    .pin_test(instr.input_pin_test),
    .flags(flags),
    .branch_test_code_true(branch_test_code_now)
  );

  always_comb begin
    logic [2:0] grp;
    grp = instr.arith_op_select[3:1];
    next_dec = '0;
    next_dec.nop = (instr.arith_op_select == `DSPD_ARITH_NOP);
    next_dec.alu_op = instr.arith_op_select[`DSPD_ARITH_ALU_BIT];
    next_dec.alu_func = instr.arith_op_select[3:0];
    next_dec.mac_op = !next_dec.nop && !next_dec.alu_op;
    if (next_dec.mac_op) begin
      if (grp[2:1] == 2'h0 && !instr.arith_op_select[2]) begin
        // rounded forms work on signed pairs
        next_dec.mac_round = 1'b1;
        next_dec.x_signed = 1'b1;
        next_dec.y_signed = 1'b1;
        next_dec.mac_acc_add = (instr.arith_op_select == `DSPD_ARITH_RND_ADD);
        next_dec.mac_acc_sub = (instr.arith_op_select == `DSPD_ARITH_RND_SUB);
      end else begin
        next_dec.x_signed = !instr.arith_op_select[1];
        next_dec.y_signed = !instr.arith_op_select[0];
        next_dec.mac_acc_add = (instr.arith_op_select[4:2] == `DSPD_ARITH_ADD);
        next_dec.mac_acc_sub = (instr.arith_op_select[4:2] == `DSPD_ARITH_SUB);
      end
    end
    next_dec.branch_test_code_true = branch_test_code_now;
    next_dec.loop_count_pop = instr.loop_count_pop;
    next_dec.loop_stack_pop = instr.loop_stack_pop;
    next_dec.pc_stack_pop = instr.pc_stack_pop;
    next_dec.mem_read = instr.mem_access && !instr.mem_dir;
    next_dec.mem_write = instr.mem_access && instr.mem_dir;
    next_dec.dag_second = instr.mem_access && instr.dag_select;
    if (instr.dual_fetch) begin
      next_dec.x_target[instr.x_side_fetch_target] = 1'b1;
      next_dec.y_target[instr.y_side_fetch_target] = 1'b1;
    end
    if (instr.data_reg_used) begin
      next_dec.data_reg_sel[instr.data_reg_code] = 1'b1;
    end
  end

  // decode pipeline: one register stage between sequencer and datapath
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dec <= '0;
    end else if (go) begin
      dec <= next_dec;
    end else begin
      // pops and memory strobes must not repeat on idle cycles
      dec.loop_count_pop <= 1'b0;
      dec.loop_stack_pop <= 1'b0;
      dec.pc_stack_pop <= 1'b0;
      dec.mem_read <= 1'b0;
      dec.mem_write <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= go;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_out <= `DSPD_FLAG_RST;
    end else if (go) begin
      unique case (instr.out_pin_action)
        `DSPD_PIN_KEEP: flag_out <= flag_out;
        `DSPD_PIN_TOGGLE: flag_out <= !flag_out;
        `DSPD_PIN_CLEAR: flag_out <= 1'b0;
        `DSPD_PIN_SET: flag_out <= 1'b1;
      endcase
    end
  end

  generate
    for (genvar m = 0; m < NMODES; m++) begin : g_mode
      dspd_mode_bit u_mode (
        .mclk(mclk),
        .rst(rst),
        .apply(go && instr.mode_valid),
        .code(instr.mode_ctl[2*m+1 -: 2]),
        .sw_we(sw_mode_we),
        .sw_val(avs_writedata[m]),
        .mode(modes[m])
      );
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      last_branch_test_code <= 1'b0;
    end else if (go) begin
      last_branch_test_code <= branch_test_code_now;
    end
  end

  // a decode in the same cycle as a software clear still counts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dec_count <= '0;
    end else if (bus_done && avs_write && avs_address == `DSPD_OFS_CNT) begin
      dec_count <= go ? CNT_W'(1) : '0;
    end else if (go) begin
      dec_count <= dec_count + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      decode_en <= `DSPD_CTRL_RST;
    end else if (bus_done && avs_write && avs_address == `DSPD_OFS_CTRL) begin
      decode_en <= avs_writedata[`DSPD_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_st <= BUS_IDLE;
    end else begin
      unique case (bus_st)
        BUS_IDLE: bus_st <= bus_req ? BUS_ACK : BUS_IDLE;
        BUS_ACK: bus_st <= BUS_IDLE;
      endcase
    end
  end

  // read data are captured in the wait cycle so they come from flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && bus_st == BUS_IDLE) begin
      avs_readdata <= '0;
      unique case (avs_address)
        `DSPD_OFS_CTRL: avs_readdata[`DSPD_CTRL_EN_BIT] <= decode_en;
        `DSPD_OFS_MODE: avs_readdata[NMODES-1:0] <= modes;
        `DSPD_OFS_STAT: begin
          avs_readdata[`DSPD_STAT_FLAG_BIT] <= flag_out;
          avs_readdata[`DSPD_STAT_BRANCH_TEST_CODE_BIT] <= last_branch_test_code;
        end
        `DSPD_OFS_CNT: avs_readdata[CNT_W-1:0] <= dec_count;
        default: avs_readdata <= '0;
      endcase
    end
  end

  // short names that keep the assertion lines readable
  logic cc_go;
  logic [3:0] cc_code;
  logic [4:0] op_code;
  logic lt_now;
  logic [1:0] timer_pair;

  assign cc_go = go && !instr.use_pin_test;
  assign cc_code = instr.branch_test_code;
  assign op_code = instr.arith_op_select;
  assign lt_now = flags.an ^ flags.av;
  assign timer_pair = instr.mode_ctl[2*`DSPD_MODE_TIMER+1 -: 2];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_arith_nop: assert property (go && instr.arith_op_select == `DSPD_ARITH_NOP
      |=> dec.nop && !dec.mac_op && !dec.alu_op)
    else $error("zero arithmetic field not decoded as no-op");
  a_arith_unit: assert property (go && instr.arith_op_select != `DSPD_ARITH_NOP
      |=> dec.alu_op == $past(instr.arith_op_select[4]) && dec.mac_op != dec.alu_op)
    else $error("arithmetic unit choice wrong");
  a_mac_round: assert property (go && op_code != `DSPD_ARITH_NOP && op_code <= `DSPD_ARITH_RND_SUB
      |=> dec.mac_round && dec.x_signed && dec.y_signed)
    else $error("rounded product not decoded");
  a_mac_add: assert property (go && op_code[4:2] == `DSPD_ARITH_ADD
      |=> dec.mac_acc_add && !dec.mac_acc_sub && !dec.mac_round)
    else $error("accumulating product not decoded");
  a_mac_sub: assert property (go && op_code[4:2] == `DSPD_ARITH_SUB
      |=> dec.mac_acc_sub && dec.x_signed == !$past(op_code[1]) && dec.y_signed == !$past(op_code[0]))
    else $error("subtracting product not decoded");
  a_branch_test_code_always: assert property (go && !instr.use_pin_test && instr.branch_test_code == `DSPD_CC_ALWAYS
      |=> dec.branch_test_code_true)
    else $error("always condition not true");
  a_branch_test_code_counter: assert property (go && !instr.use_pin_test && instr.branch_test_code == `DSPD_CC_NCE
      |=> dec.branch_test_code_true == !$past(flags.ce))
    else $error("counter condition wrong");
  a_branch_test_code_equal: assert property (cc_go && cc_code == `DSPD_CC_EQ
      |=> dec.branch_test_code_true == $past(flags.az))
    else $error("equal condition wrong");
  a_branch_test_code_unequal: assert property (cc_go && cc_code == `DSPD_CC_NE
      |=> dec.branch_test_code_true == !$past(flags.az))
    else $error("not equal condition wrong");
  a_branch_test_code_greater: assert property (cc_go && cc_code == `DSPD_CC_GT
      |=> dec.branch_test_code_true == (!$past(lt_now) && !$past(flags.az)))
    else $error("greater condition wrong");
  a_branch_test_code_less_eq: assert property (cc_go && cc_code == `DSPD_CC_LE
      |=> dec.branch_test_code_true == ($past(lt_now) || $past(flags.az)))
    else $error("less or equal condition wrong");
  a_branch_test_code_less: assert property (cc_go && cc_code == `DSPD_CC_LT
      |=> dec.branch_test_code_true == $past(lt_now))
    else $error("less condition wrong");
  a_branch_test_code_greater_eq: assert property (cc_go && cc_code == `DSPD_CC_GE
      |=> dec.branch_test_code_true == !$past(lt_now))
    else $error("greater or equal condition wrong");
  a_alu_overflow: assert property (cc_go && cc_code == `DSPD_CC_AV
      |=> dec.branch_test_code_true == $past(flags.av))
    else $error("overflow condition wrong");
  a_no_overflow: assert property (cc_go && cc_code == `DSPD_CC_NAV
      |=> dec.branch_test_code_true == !$past(flags.av))
    else $error("no overflow condition wrong");
  a_alu_carry: assert property (cc_go && cc_code == `DSPD_CC_AC
      |=> dec.branch_test_code_true == $past(flags.ac))
    else $error("carry condition wrong");
  a_branch_test_code_carry: assert property (go && !instr.use_pin_test && instr.branch_test_code == `DSPD_CC_NAC
      |=> dec.branch_test_code_true == !$past(flags.ac))
    else $error("carry complement condition wrong");
  a_x_negative: assert property (cc_go && cc_code == `DSPD_CC_NEG
      |=> dec.branch_test_code_true == $past(flags.ax_neg))
    else $error("negative sign condition wrong");
  a_x_positive: assert property (cc_go && cc_code == `DSPD_CC_POS
      |=> dec.branch_test_code_true == !$past(flags.ax_neg))
    else $error("positive sign condition wrong");
  a_mac_overflow: assert property (cc_go && cc_code == `DSPD_CC_MV
      |=> dec.branch_test_code_true == $past(flags.mv))
    else $error("product overflow condition wrong");
  a_mac_no_ovf: assert property (cc_go && cc_code == `DSPD_CC_NMV
      |=> dec.branch_test_code_true == !$past(flags.mv))
    else $error("no product overflow condition wrong");
  a_cnt_pop: assert property (go |=> dec.loop_count_pop == $past(instr.loop_count_pop))
    else $error("counter stack pop mismatch");
  a_pop_once: assert property (!go |=> !dec.loop_count_pop && !dec.loop_stack_pop && !dec.pc_stack_pop)
    else $error("pop repeated without instruction");
  a_mem_dir: assert property (go && instr.mem_access |=> dec.mem_write == $past(instr.mem_dir)
      && dec.mem_read != dec.mem_write)
    else $error("memory direction wrong");
  a_x_target: assert property (go && instr.dual_fetch
      |=> dec.x_target == (4'h1 << $past(instr.x_side_fetch_target)))
    else $error("x fetch target wrong");
  a_y_target: assert property (go && instr.dual_fetch
      |=> dec.y_target == (4'h1 << $past(instr.y_side_fetch_target)))
    else $error("y fetch target wrong");
  a_flag_toggle: assert property (go && instr.out_pin_action == `DSPD_PIN_TOGGLE
      |=> flag_out != $past(flag_out))
    else $error("flag toggle failed");
  a_flag_set: assert property (go && instr.out_pin_action == `DSPD_PIN_SET
      |=> flag_out ##1 (flag_out || $past(go)))
    else $error("flag set failed");
  a_flag_clear: assert property (go && instr.out_pin_action == `DSPD_PIN_CLEAR |=> !flag_out)
    else $error("flag clear failed");
  a_flag_keep: assert property (go && instr.out_pin_action == `DSPD_PIN_KEEP |=> $stable(flag_out))
    else $error("flag changed on keep");
  a_flag_idle: assert property (!go |=> $stable(flag_out))
    else $error("flag changed without instruction");
  a_dag_pick: assert property (go && instr.mem_access |=> dec.dag_second == $past(instr.dag_select))
    else $error("address generator pick wrong");
  a_pc_pop: assert property (go |=> dec.pc_stack_pop == $past(instr.pc_stack_pop)
      && dec.loop_stack_pop == $past(instr.loop_stack_pop))
    else $error("stack pop mismatch");
  a_mode_set: assert property (go && instr.mode_valid && timer_pair == `DSPD_MC_ON
      |=> modes[`DSPD_MODE_TIMER])
    else $error("timer mode not activated");
  a_mode_clear: assert property (go && instr.mode_valid && timer_pair == `DSPD_MC_OFF
      |=> !modes[`DSPD_MODE_TIMER])
    else $error("timer mode not deactivated");
  a_mode_keep: assert property (go && instr.mode_valid && !sw_mode_we
      && !instr.mode_ctl[2*`DSPD_MODE_BANK+`DSPD_MC_ARM_BIT] |=> $stable(modes[`DSPD_MODE_BANK]))
    else $error("unarmed mode changed");
  a_mode_hold: assert property (!(go && instr.mode_valid) && !sw_mode_we |=> $stable(modes))
    else $error("modes changed without cause");
  a_data_reg_sel: assert property (go && instr.data_reg_used
      |=> dec.data_reg_sel == (16'h0001 << $past(instr.data_reg_code)))
    else $error("data register select wrong");
  a_pin_test: assert property (go && instr.use_pin_test
      |=> dec.branch_test_code_true == ($past(flags.flag_in) == $past(instr.input_pin_test)))
    else $error("pin test condition wrong");
  a_bus_wait: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer later than one wait cycle");

  c_mac_acc: cover property (go && instr.arith_op_select[4:2] == `DSPD_ARITH_SUB);
  c_mode_write: cover property (go && instr.mode_valid ##1 modes != $past(modes));
  c_flag_toggle: cover property (go && instr.out_pin_action == `DSPD_PIN_TOGGLE);
  c_pin_test: cover property (go && instr.use_pin_test && instr.input_pin_test);
  c_bus_read: cover property (avs_read && !avs_waitrequest);
endmodule

// [test_dspd_decoder.sv]
`timescale 1ns/1ps
`include "dspd_consts.svh"

module test_dspd_decoder;
  import dspd_pkg::*;
  logic mclk;
  logic rst;
  logic instr_valid;
  dspd_instr_t instr;
  dspd_flags_t flags;
  dspd_dec_t dec;
  logic dec_valid;
  logic flag_out;
  logic [NMODES-1:0] modes;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rd;
  logic exp_flag;
  int err_total;
  int n_compared;

  dspd_decoder #(.CNT_W(16)) dut (
    .mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .flags(flags),
    .dec(dec), .dec_valid(dec_valid), .flag_out(flag_out), .modes(modes),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until the edge after waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) err_total++;
    @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // one instruction for one cycle; returns just after the taking edge
  task automatic issue(input dspd_instr_t i, input dspd_flags_t f, input logic en);
    @(posedge mclk);
    instr <= i;
    flags <= f;
    instr_valid <= 1'b1;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    chk(dec_valid, en);
  endtask

  task automatic t_regs();
    bus(1'b0, `DSPD_OFS_CTRL, 32'h0, rd);
    chk(rd, 32'h1);
    bus(1'b0, `DSPD_OFS_MODE, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, `DSPD_OFS_STAT, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, `DSPD_OFS_CNT, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, 4'h6, 32'hffffffff, rd);
    bus(1'b0, 4'h6, 32'h0, rd);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_arith();
    dspd_instr_t i;
    logic [4:0] c;
    logic m;
    for (int k = 0; k < 32; k++) begin
      i = '0;
      c = k[4:0];
      i.arith_op_select = c;
      issue(i, 8'h00, 1'b1);
      m = !c[4] && c != 5'h00;
      chk({dec.nop, dec.mac_op, dec.alu_op}, {c == 5'h00, m, c[4]});
      chk(dec.mac_round, m && c < 5'h04);
      chk(dec.mac_acc_add, m && (c == 5'h02 || c[3:2] == 2'h2));
      chk(dec.mac_acc_sub, m && (c == 5'h03 || c[3:2] == 2'h3));
      if (m) chk({dec.x_signed, dec.y_signed}, c < 5'h04 ? 2'h3 : {!c[1], !c[0]});
      if (c[4]) chk(dec.alu_func, c[3:0]);
    end
    $display("test arith done");
  endtask

  task automatic t_branch_test_code();
    dspd_instr_t i;
    dspd_flags_t f;
    logic [15:0] e;
    logic lt;
    logic [7:0] pat[4] = '{8'hb5, 8'h4a, 8'h60, 8'h40};
    for (int p = 0; p < 4; p++) begin
      f = pat[p];
      lt = f.an ^ f.av;
      e = {1'b1, !f.ce, !f.mv, f.mv, !f.ax_neg, f.ax_neg, !f.ac, f.ac, !f.av, f.av,
           !lt, lt, lt || f.az, !lt && !f.az, !f.az, f.az};
      for (int c = 0; c < 16; c++) begin
        i = '0;
        i.branch_test_code = c[3:0];
        issue(i, f, 1'b1);
        chk(dec.branch_test_code_true, e[c]);
      end
      for (int b = 0; b < 2; b++) begin
        i = '0;
        i.use_pin_test = 1'b1;
        i.input_pin_test = b[0];
        issue(i, f, 1'b1);
        chk(dec.branch_test_code_true, b[0] == f.flag_in);
      end
    end
    $display("test branch_test_code done");
  endtask

  task automatic t_strobe();
    dspd_instr_t i;
    for (int k = 0; k < 16; k++) begin
      i = '0;
      i.loop_count_pop = k[0];
      i.loop_stack_pop = k[1];
      i.pc_stack_pop = k[2];
      i.mem_access = 1'b1;
      i.mem_dir = k[3];
      i.dag_select = k[0] ^ k[3];
      issue(i, 8'h00, 1'b1);
      chk({dec.loop_count_pop, dec.loop_stack_pop, dec.pc_stack_pop}, {k[0], k[1], k[2]});
      chk({dec.mem_read, dec.mem_write}, {!k[3], k[3]});
      chk(dec.dag_second, k[0] ^ k[3]);
      @(posedge mclk);
      #1;
      chk({dec.loop_count_pop, dec.loop_stack_pop, dec.pc_stack_pop, dec.mem_read, dec.mem_write}, 5'h00);
    end
    $display("test strobe done");
  endtask

  task automatic t_fetch();
    dspd_instr_t i;
    for (int k = 0; k < 17; k++) begin
      i = '0;
      i.dual_fetch = k < 16;
      i.data_reg_used = k < 16;
      i.x_side_fetch_target = k[1:0];
      i.y_side_fetch_target = k[3:2];
      i.data_reg_code = k[3:0];
      issue(i, 8'h00, 1'b1);
      chk(dec.x_target, k < 16 ? 4'h1 << k[1:0] : 4'h0);
      chk(dec.y_target, k < 16 ? 4'h1 << k[3:2] : 4'h0);
      chk(dec.data_reg_sel, k < 16 ? 16'h1 << k[3:0] : 16'h0);
    end
    $display("test fetch done");
  endtask

  task automatic t_flag();
    dspd_instr_t i;
    logic [1:0] seq[8] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h2, 2'h1, 2'h2, 2'h3};
    exp_flag = 1'b0;
    for (int k = 0; k < 8; k++) begin
      i = '0;
      i.out_pin_action = seq[k];
      i.branch_test_code = `DSPD_CC_ALWAYS;
      issue(i, 8'h00, 1'b1);
      exp_flag = seq[k] == 2'h1 ? !exp_flag : seq[k] == 2'h0 ? exp_flag : seq[k][0];
      chk(flag_out, exp_flag);
    end
    bus(1'b0, `DSPD_OFS_STAT, 32'h0, rd);
    chk(rd[1:0], {1'b1, exp_flag});
    $display("test flag done");
  endtask

  task automatic t_modes();
    dspd_instr_t i;
    logic [NMODES-1:0] em;
    em = '0;
    for (int s = 1; s >= 0; s--) begin
      for (int m = 0; m < NMODES; m++) begin
        i = '0;
        i.mode_valid = 1'b1;
        i.mode_ctl = 14'h1555;
        i.mode_ctl[2*m +: 2] = {1'b1, s[0]};
        issue(i, 8'h00, 1'b1);
        em[m] = s[0];
        chk(modes, em);
      end
      bus(1'b0, `DSPD_OFS_MODE, 32'h0, rd);
      chk(rd, s ? 32'h7f : 32'h0);
    end
    bus(1'b1, `DSPD_OFS_MODE, 32'h2a, rd);
    @(posedge mclk);
    #1;
    chk(modes, 7'h2a);
    $display("test modes done");
  endtask

  task automatic t_gate();
    dspd_instr_t i;
    i = '0;
    bus(1'b1, `DSPD_OFS_CNT, 32'h0, rd);
    issue(i, 8'h00, 1'b1);
    issue(i, 8'h00, 1'b1);
    bus(1'b1, `DSPD_OFS_CTRL, 32'h0, rd);
    i.out_pin_action = exp_flag ? `DSPD_PIN_CLEAR : `DSPD_PIN_SET;
    issue(i, 8'h00, 1'b0);
    chk(flag_out, exp_flag);
    bus(1'b0, `DSPD_OFS_CNT, 32'h0, rd);
    chk(rd, 32'h2);
    bus(1'b1, `DSPD_OFS_CTRL, 32'h1, rd);
    issue(i, 8'h00, 1'b1);
    chk(flag_out, !exp_flag);
    $display("test gate done");
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the whole run needs well under 3000 cycles
  initial begin
    #(50 * 20000);
    err_total++;
    conclude();
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    flags = '0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_arith();
    t_branch_test_code();
    t_strobe();
    t_fetch();
    t_flag();
    t_modes();
    t_gate();
    conclude();
  end
endmodule
